/* File: verilog/erf_rx_filter.sv */
// Purpose: rx control-frame filter, cut-through / store-forward, link fault rs
// Assumes: rx and tx columns and frame beats are on ref_clk
// Notes: registers over axi4-lite, one aligned word each
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "erf_defines.svh"
module erf_rx_filter #(
    parameter int BUF_DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic ref_clk, // 50 mhz clock
    input wire logic rst_n, // async reset, low
    input wire logic [AW-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [AW-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire erf_pkg::erf_col_t rxCol, // column from phy
    input wire erf_pkg::erf_col_t txColIn, // column from tx mac
    output erf_pkg::erf_col_t txColOut, // column to phy
    input wire erf_pkg::erf_beat_t inBeat, // frame beat from rx mac
    input wire logic inValid, // beat valid
    output logic inReady, // beat accepted
    output erf_pkg::erf_beat_t outBeat, // frame beat to client
    output logic outValid, // client beat valid
    input wire logic outReady, // client ready
    output logic pauseDet, // pause frame seen, pulse
    output logic remoteFaultFromRx, // far-end fault, rx side
    output logic localFaultFromRx, // near-end fault, rx side
    output logic remoteFaultStatus, // far-end fault status
    output logic localFaultStatus // near-end fault status
);
    import erf_pkg::*;
    localparam int PW = $clog2(BUF_DEPTH);
    //------------------------------------------------
    // configuration registers
    //------------------------------------------------
    logic [5:0] filtCtl;
    logic [1:0] lfCfg;
    logic [3:0] seqCfg;
    logic [47:0] ownMac;
    logic wrGo;
    logic [7:0] wa;
    assign wa = 8'(s_axi_awaddr);
    assign wrGo = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wrGo;
    assign s_axi_wready = wrGo;
    // byte enables merge into the old register word
    function automatic logic [31:0] merge(input logic [31:0] o);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++)
            if (s_axi_wstrb[i]) r[i*8 +: 8] = s_axi_wdata[i*8 +: 8];
        return r;
    endfunction
    // register writes; filter bits reset set
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            filtCtl <= `ERF_FILT_RST;
            lfCfg <= 2'b00;
            seqCfg <= `ERF_SEQ_RST;
            ownMac <= 48'h0;
        end
        else if (wrGo)
        begin
            case (wa)
                `ERF_A_FILT: filtCtl <= 6'(merge({26'h0, filtCtl}));
                `ERF_A_LFCFG: lfCfg <= 2'(merge({30'h0, lfCfg}));
                `ERF_A_SEQCFG: seqCfg <= 4'(merge({28'h0, seqCfg}));
                `ERF_A_MACLO: ownMac[31:0] <= merge(ownMac[31:0]);
                `ERF_A_MACHI: ownMac[47:32] <= 16'(merge({16'h0, ownMac[47:32]}));
                default: ;
            endcase
        end
    end
    // write response; unmapped offsets answer slverr
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ERF_RESP_OK;
        end
        else if (wrGo)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wa > `ERF_A_MACHI || wa[1:0] != 2'b00) ? `ERF_RESP_ERR : `ERF_RESP_OK;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end
    //------------------------------------------------
    // register reads
    //------------------------------------------------
    logic sfMode, farFlag, nearFlag, lfOn;
    erf_fault_t linkFault;
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `ERF_RESP_OK;
        end
        else if (s_axi_arvalid && !s_axi_rvalid)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `ERF_RESP_OK;
            case (8'(s_axi_araddr))
                `ERF_A_FILT: s_axi_rdata <= {26'h0, filtCtl};
                `ERF_A_LFCFG: s_axi_rdata <= {30'h0, lfCfg};
                `ERF_A_SEQCFG: s_axi_rdata <= {28'h0, seqCfg};
                `ERF_A_STAT: s_axi_rdata <= {26'h0, linkFault, sfMode, nearFlag, farFlag, lfOn};
                `ERF_A_MACLO: s_axi_rdata <= ownMac[31:0];
                `ERF_A_MACHI: s_axi_rdata <= {16'h0, ownMac[47:32]};
                default:
                begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `ERF_RESP_ERR;
                end
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
    //------------------------------------------------
    // frame mode and header decode
    //------------------------------------------------
    logic gen, sfWant, inFrame, take, isCtl, isPause;
    logic [7:0] wIdx;
    logic [47:0] da;
    logic [15:0] typ, opc;
    assign gen = filtCtl[`ERF_B_GEN];
    // runt rejection alone keeps cut-through
    assign sfWant = gen && |filtCtl[`ERF_B_CTRL:`ERF_B_FCS];
    assign take = inValid && inReady;
    assign typ = {inBeat.data[39:32], inBeat.data[47:40]};
    assign opc = {inBeat.data[55:48], inBeat.data[63:56]};
    // mode changes only between frames, never mid-frame
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sfMode <= 1'b1;
            inFrame <= 1'b0;
        end
        else
        begin
            if (!inFrame && !(take && inBeat.sop))
                sfMode <= sfWant;
            if (take)
                inFrame <= !inBeat.eop;
        end
    end
    // header capture; pause detect is independent of forwarding
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wIdx <= 8'h0;
            da <= 48'h0;
            isCtl <= 1'b0;
            isPause <= 1'b0;
            pauseDet <= 1'b0;
        end
        else
        begin
            pauseDet <= 1'b0;
            if (take)
            begin
                wIdx <= inBeat.eop ? 8'h0 : (wIdx == 8'hff ? wIdx : wIdx + 8'h1);
                if (inBeat.sop)
                begin
                    da <= inBeat.data[47:0];
                    isCtl <= 1'b0;
                    isPause <= 1'b0;
                end
                if (wIdx == 8'h1)
                begin
                    isCtl <= typ == `ERF_CTL_TYPE;
                    isPause <= typ == `ERF_CTL_TYPE && opc == `ERF_OP_PAUSE;
                    pauseDet <= typ == `ERF_CTL_TYPE && opc == `ERF_OP_PAUSE;
                end
            end
        end
    end
    // drop decision at end of frame
    logic dropNow, daOk;
    assign daOk = da[0] || da == ownMac;
    always_comb
    begin
        dropNow = 1'b0;
        if (gen)
        begin
            if (filtCtl[`ERF_B_PAUSE] && isPause) dropNow = 1'b1;
            if (filtCtl[`ERF_B_CTRL] && isCtl && !isPause) dropNow = 1'b1;
            // without address filter no pause is refused for its address
            if (filtCtl[`ERF_B_ADDR] && !daOk) dropNow = 1'b1;
            if (filtCtl[`ERF_B_FCS] && inBeat.err) dropNow = 1'b1;
            if (filtCtl[`ERF_B_RUNT] && wIdx < `ERF_RUNT_WORDS - 8'h1) dropNow = 1'b1;
        end
    end
    //------------------------------------------------
    // store-forward buffer and client output
    //------------------------------------------------
    erf_beat_t mem [BUF_DEPTH];
    logic [PW-1:0] wPtr, rPtr, lastPtr;
    logic overrun, outFree;
    erf_buf_t bufSt;
    assign outFree = !outValid || outReady;
    // a drain left over from a mode switch must finish before cut-through beats enter
    assign inReady = bufSt == ERF_FILL && (sfMode || outFree);
    // buffer words need no reset, only the pointers do
    always_ff @(posedge ref_clk)
        if (take && sfMode)
            mem[wPtr] <= inBeat;
    // fill pointer, overrun and hand-off to drain
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wPtr <= '0;
            lastPtr <= '0;
            overrun <= 1'b0;
            bufSt <= ERF_FILL;
        end
        else if (bufSt == ERF_FILL)
        begin
            if (take && sfMode)
            begin
                // a frame longer than the buffer is dropped whole
                if (wPtr == PW'(BUF_DEPTH - 1) && !inBeat.eop)
                    overrun <= 1'b1;
                else
                    wPtr <= wPtr + PW'(1);
                if (inBeat.eop)
                begin
                    wPtr <= '0;
                    overrun <= 1'b0;
                    lastPtr <= wPtr;
                    if (!dropNow && !overrun) bufSt <= ERF_DRAIN;
                end
            end
        end
        else if (outFree && rPtr == lastPtr)
            bufSt <= ERF_FILL;
    end
    // output register: cut-through copies, drain reads the buffer
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            outValid <= 1'b0;
            outBeat <= '0;
            rPtr <= '0;
        end
        else if (outFree)
        begin
            outValid <= 1'b0;
            if (bufSt == ERF_DRAIN)
            begin
                outValid <= 1'b1;
                outBeat <= mem[rPtr];
                rPtr <= rPtr == lastPtr ? '0 : rPtr + PW'(1);
            end
            else if (!sfMode && take)
            begin
                outValid <= 1'b1;
                outBeat <= inBeat;
            end
        end
    end
    //------------------------------------------------
    // rx link fault monitor
    //------------------------------------------------
    logic isSeq;
    erf_fault_t seqVal, lastSeq;
    logic [2:0] seqCnt;
    logic [7:0] colCnt;
    assign lfOn = lfCfg == `ERF_LF_ON;
    assign isSeq = rxCol.ctl[0] && rxCol.data[7:0] == `ERF_SEQ_CH
        && (rxCol.data[31:24] == `ERF_LF_CODE || rxCol.data[31:24] == `ERF_RF_CODE);
    assign seqVal = rxCol.data[31:24] == `ERF_RF_CODE ? ERF_REMOTE : ERF_LOCAL;
    // counts columns since the last fault set; four close equal sets latch it
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            linkFault <= ERF_OK;
            lastSeq <= ERF_OK;
            seqCnt <= 3'h0;
            colCnt <= 8'h0;
        end
        else if (isSeq)
        begin
            colCnt <= 8'h0;
            if (seqVal == lastSeq && colCnt < `ERF_COLS && seqCnt != 3'h0)
            begin
                if (seqCnt == `ERF_NSEQ - 3'h1)
                    linkFault <= seqVal;
                else
                    seqCnt <= seqCnt + 3'h1;
            end
            else
            begin
                seqCnt <= 3'h1;
                lastSeq <= seqVal;
            end
        end
        else if (colCnt == `ERF_COLS - 8'h1)
        begin
            linkFault <= ERF_OK;
            seqCnt <= 3'h0;
        end
        else
            colCnt <= colCnt + 8'h1;
    end
    // fault flags follow the state; held low while signalling is off
    assign farFlag = lfOn && linkFault == ERF_REMOTE;
    assign nearFlag = lfOn && linkFault == ERF_LOCAL;
    assign remoteFaultFromRx = farFlag;
    assign localFaultFromRx = nearFlag;
    assign remoteFaultStatus = farFlag;
    assign localFaultStatus = nearFlag;
    //------------------------------------------------
    // tx fault response
    //------------------------------------------------
    logic tx_far_end_fault_in, tx_near_end_fault_in;
    erf_act_t act;
    assign tx_far_end_fault_in = farFlag;
    assign tx_near_end_fault_in = nearFlag;
    always_comb
    begin
        act = ERF_ACT_NORM;
        // local fault wins: the link is not usable at all
        if (tx_near_end_fault_in) act = erf_act_t'(seqCfg[1:0]);
        else if (tx_far_end_fault_in) act = erf_act_t'(seqCfg[3:2]);
    end
    // column to the phy is always registered, idle out of reset
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            txColOut <= '{data: `ERF_IDLE_COL, ctl: 8'hff};
        else
            case (act)
                ERF_ACT_RF: txColOut <= '{data: `ERF_RF_COL, ctl: 8'h11};
                ERF_ACT_IDLE: txColOut <= '{data: `ERF_IDLE_COL, ctl: 8'hff};
                default: txColOut <= txColIn;
            endcase
    end
    //------------------------------------------------
    // checks
    //------------------------------------------------
    chk_flags_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !lfOn |-> !remoteFaultFromRx && !localFaultFromRx)
        else $error("fault output high while signalling off");
    chk_filt_reset: assert property (@(posedge ref_clk)
        $rose(rst_n) |-> filtCtl[`ERF_B_PAUSE] && filtCtl[`ERF_B_CTRL])
        else $error("filter bits not set after reset");
    chk_pause_drop: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take && inBeat.eop && sfMode && gen && filtCtl[`ERF_B_PAUSE] && isPause
        |=> bufSt == ERF_FILL)
        else $error("pause frame kept while filtered");
    chk_ctl_drop: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take && inBeat.eop && sfMode && gen && filtCtl[`ERF_B_CTRL] && isCtl && !isPause
        |=> bufSt == ERF_FILL)
        else $error("control frame kept while filtered");
    chk_cut_pass: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take && !sfMode |=> outValid && outBeat == $past(inBeat))
        else $error("cut-through beat not passed");
    chk_mode_sel: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !inFrame && !take ##1 !inFrame |-> sfMode == $past(sfWant))
        else $error("mode not following filter settings");
    chk_quiet_ok: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !isSeq [*8] ##0 colCnt == `ERF_COLS - 8'h1 ##1 !isSeq |-> linkFault == ERF_OK)
        else $error("fault state not cleared after quiet interval");
    chk_fault_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        isSeq && seqVal == lastSeq && colCnt < `ERF_COLS && seqCnt == 3'h3
        |=> linkFault == $past(seqVal))
        else $error("fourth fault set not latched");
    chk_tx_rf: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tx_near_end_fault_in && seqCfg[1:0] == 2'b01 |=> txColOut.data == `ERF_RF_COL)
        else $error("remote fault not sent on local fault");
    chk_pause_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
        take && wIdx == 8'h1 && typ == `ERF_CTL_TYPE && opc == `ERF_OP_PAUSE |=> pauseDet)
        else $error("pause detect missing");
endmodule // erf_rx_filter

/* File: include/erf_defines.svh */
// How it works
// - control bit 4 turns dropping of received pause frames on or off.
// - control bit 5 turns dropping of other mac control frames on or off.
// - both filter bits come out of reset set, so filtering is on.
// - filter bits only act while control bit 0, the global enable, is set.
// - pause filtering drops type 0x8808 opcode 0x1 frames before the client.
// - control filtering drops type 0x8808 frames with any other opcode.
// - pause filter off, address filter off: every pause frame is forwarded.
// - pause filter off, address filter on: only multicast or own-address pauses.
// - forwarding choices never change the pause detect pulse to the mac.
// - no criterion but runt enabled gives cut-through, no whole-frame buffering.
// - any criterion beyond runt buffers and checks each whole frame first.
// - cut-through passes every identifiable frame whatever its destination.
// - fault signalling off at reset; on when fault config bits [1:0] are 01.
// - enabled, tx sends remote fault on local fault, idles on remote fault.
// - a sequence config field picks fault set, idle or traffic per fault.
// - receive side raises far or near fault flag on those ordered sets.
// - a flag clears after more than 127 columns without fault sets.
// - state takes a fault after four equal sets under 128 columns apart.
// - state returns to ok after 128 columns with no fault set.
// - with signalling off, both fault outputs stay present and held low.
// - receive fault flags feed tx fault inputs and the status outputs.
// Purpose: register map, field positions and codes of the rx filter block
// Assumes: one 32-bit aligned word per register
// Notes: included by bare name
`ifndef ERF_DEFINES_SVH
`define ERF_DEFINES_SVH
`define ERF_A_FILT 8'h00
`define ERF_A_LFCFG 8'h04
`define ERF_A_SEQCFG 8'h08
`define ERF_A_STAT 8'h0c
`define ERF_A_MACLO 8'h10
`define ERF_A_MACHI 8'h14
`define ERF_FILT_RST 6'h31
`define ERF_SEQ_RST 4'h9
`define ERF_B_GEN 0
`define ERF_B_RUNT 1
`define ERF_B_FCS 2
`define ERF_B_ADDR 3
`define ERF_B_PAUSE 4
`define ERF_B_CTRL 5
`define ERF_LF_ON 2'b01
`define ERF_CTL_TYPE 16'h8808
`define ERF_OP_PAUSE 16'h0001
`define ERF_COLS 8'd128
`define ERF_NSEQ 3'd4
`define ERF_SEQ_CH 8'h9c
`define ERF_LF_CODE 8'h01
`define ERF_RF_CODE 8'h02
`define ERF_RF_COL 64'h0200009c_0200009c
`define ERF_IDLE_COL 64'h07070707_07070707
`define ERF_RUNT_WORDS 8'd8
`define ERF_RESP_OK 2'b00
`define ERF_RESP_ERR 2'b10
`endif

/* File: include/erf_pkg.sv */
// Purpose: shared types of the rx filter and link fault block
// Assumes: one 64-bit column per clock on both mii sides
// Notes: frame beats carry byte 0 in the low bits
package erf_pkg;
    typedef struct packed {
        logic [63:0] data;
        logic [7:0] ctl;
    } erf_col_t;
    typedef struct packed {
        logic [63:0] data;
        logic sop;
        logic eop;
        logic err;
    } erf_beat_t;
    typedef enum logic [1:0] {ERF_OK, ERF_LOCAL, ERF_REMOTE} erf_fault_t;
    typedef enum logic [1:0] {ERF_ACT_NORM, ERF_ACT_RF, ERF_ACT_IDLE} erf_act_t;
    typedef enum logic {ERF_FILL, ERF_DRAIN} erf_buf_t;
endpackage

/* File: testbench/erf_phy_model.sv */
// Purpose: far-end phy model, feeds receive columns to the block
// Assumes: one 64-bit column per ref_clk, same domain as the block
// Notes: sends idle between fault sequences, never leaves the line undriven
`timescale 1ns/1ps
module erf_phy_model (
    input wire logic ref_clk, // column clock
    input wire logic seqOn, // send a sequence set this column
    input wire logic [7:0] seqCode, // 01 local, 02 remote
    output erf_pkg::erf_col_t rxCol // column to the block
);
    import erf_pkg::*;
    // ----------------------------------------
    // column generator
    // ----------------------------------------
    // idle fills every column with no set, as a real link never goes silent
    always_ff @(posedge ref_clk)
    begin
        if (seqOn)
            rxCol <= '{data: {32'h0, seqCode, 16'h0, 8'h9c}, ctl: 8'h01}; // far end reports its fault
        else
            rxCol <= '{data: 64'h07070707_07070707, ctl: 8'hff};
    end
endmodule // erf_phy_model

/* File: testbench/test_erf_rx_filter.sv */
// Purpose: self-checking bench of the rx filter and link fault block
// Assumes: client always ready, registers over axi4-lite
// Notes: frames are eight beats, so runt logic never drops them
`timescale 1ns/1ps
`include "erf_defines.svh"
module test_erf_rx_filter;
    import erf_pkg::*;
    logic ref_clk, rst_n, awvalid, wvalid, bready, arvalid, rready, inValid, outReady, seqOn, awready, wready, bvalid;
    logic arready, rvalid, inReady, outValid, pauseDet, rfRx, lfRx, rfSt, lfSt;
    logic [7:0] awaddr, araddr, seqCode;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp;
    erf_col_t rxCol, txColIn, txColOut;
    erf_beat_t inBeat, outBeat, lastOut;
    int errors = 0, num_checks = 0, outCnt = 0, pauseCnt = 0, cyc = 0;
    erf_rx_filter #(.BUF_DEPTH(16)) erf_rx_filter_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rxCol(rxCol), .txColIn(txColIn), .txColOut(txColOut), .inBeat(inBeat),
        .inValid(inValid), .inReady(inReady), .outBeat(outBeat), .outValid(outValid), .outReady(outReady),
        .pauseDet(pauseDet), .remoteFaultFromRx(rfRx), .localFaultFromRx(lfRx),
        .remoteFaultStatus(rfSt), .localFaultStatus(lfSt));
    erf_phy_model erf_phy_model_inst (.ref_clk(ref_clk), .seqOn(seqOn), .seqCode(seqCode), .rxCol(rxCol));
    // ----------------------------------------
    // clock, monitors and timeout
    // ----------------------------------------
    initial
    begin
        ref_clk = 0;
        forever #10 ref_clk = ~ref_clk;
    end
    // delivered beats and pause pulses, counted where they stand
    always @(posedge ref_clk)
    begin
        cyc++;
        if (outValid === 1'b1 && outReady === 1'b1)
        begin
            outCnt++;
            lastOut = outBeat;
        end
        if (pauseDet === 1'b1) pauseCnt++;
        if (cyc == 8000)
        begin
            errors++;
            conclude();
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [71:0] seen, input logic [71:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // address and data offered together, each released once taken
    task automatic axW(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do
        begin
            @(posedge ref_clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        check("write resp", bresp, `ERF_RESP_OK);
        bready <= 0;
    endtask
    task automatic axR(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do
        begin
            @(posedge ref_clk);
            if (arready) arvalid <= 0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask
    // eight-beat control frame, type and opcode big-endian in word 1
    task automatic tFrame(input string name, input logic [5:0] filt, input logic [47:0] da,
        input logic [15:0] op, input int expBeats, input int expPause);
        erf_beat_t b;
        axW(`ERF_A_FILT, {26'h0, filt});
        outCnt = 0;
        pauseCnt = 0;
        lastOut = '0;
        for (int i = 0; i < 8; i++)
        begin
            b.data = (i == 0) ? {16'h0, da} : (i == 1) ? {op[7:0], op[15:8], 16'h0888, 32'h0} : {8{i[7:0]}};
            b.sop = (i == 0);
            b.eop = (i == 7);
            b.err = 0;
            inBeat <= b;
            inValid <= 1;
            do @(posedge ref_clk); while (inReady !== 1'b1);
        end
        inValid <= 0;
        repeat (30) @(posedge ref_clk);
        check({name, " beats"}, outCnt, expBeats);
        check({name, " pause"}, pauseCnt, expPause);
        check({name, " last"}, lastOut, (expBeats > 0) ? {64'h07070707_07070707, 3'b010} : 67'h0);
    endtask
    task automatic sets(input logic [7:0] code, input int n);
        seqCode <= code;
        seqOn <= 1;
        repeat (n) @(posedge ref_clk);
        seqOn <= 0;
        repeat (4) @(posedge ref_clk);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        logic [1:0] rr;
        {rst_n, awvalid, wvalid, bready, arvalid, rready, inValid, seqOn} = '0;
        {awaddr, araddr, wdata, seqCode, inBeat} = '0;
        outReady = 1;
        txColIn = '{data: 64'h11223344_55667788, ctl: 8'h00};
        repeat (2) @(posedge ref_clk);
        rst_n <= 1;
        axR(`ERF_A_FILT, rd, rr);
        check("filter reset", rd, 32'h31);
        axR(`ERF_A_LFCFG, rd, rr);
        check("fault cfg reset", rd, 32'h0);
        axR(8'h40, rd, rr);
        check("unmapped resp", rr, 2'b10);
        tFrame("pause dropped", 6'h31, 48'h1, 16'h1, 0, 1);
        axR(`ERF_A_STAT, rd, rr);
        check("store mode", rd[3], 1'b1);
        tFrame("ctl dropped", 6'h31, 48'h1, 16'h2, 0, 0);
        tFrame("ctl kept", 6'h11, 48'h1, 16'h2, 8, 0);
        tFrame("global off", 6'h30, 48'h2, 16'h1, 8, 1);
        tFrame("cut through", 6'h01, 48'h2, 16'h1, 8, 1);
        axR(`ERF_A_STAT, rd, rr);
        check("cut mode", rd[3], 1'b0);
        tFrame("no addr filt", 6'h21, 48'h2, 16'h1, 8, 1);
        tFrame("mcast pause", 6'h09, 48'h1, 16'h1, 8, 1);
        tFrame("ucast pause", 6'h09, 48'h2, 16'h1, 0, 1);
        axW(`ERF_A_MACLO, 32'h2);
        tFrame("own pause", 6'h09, 48'h2, 16'h1, 8, 1);
        sets(8'h01, 4);
        check("fault off", {lfRx, lfSt, rfRx, rfSt}, 4'h0);
        axW(`ERF_A_LFCFG, 32'h1);
        axR(`ERF_A_STAT, rd, rr);
        check("fault on", rd[0], 1'b1);
        repeat (140) @(posedge ref_clk);
        sets(8'h01, 3);
        check("three sets", lfRx, 1'b0);
        sets(8'h01, 1);
        check("near fault", {lfRx, lfSt, rfRx, rfSt}, 4'hc);
        check("tx rf col", txColOut, {64'h0200009c_0200009c, 8'h11});
        repeat (140) @(posedge ref_clk);
        check("near clear", {lfRx, lfSt}, 2'b00);
        sets(8'h02, 4);
        check("far fault", {lfRx, lfSt, rfRx, rfSt}, 4'h3);
        check("tx idle col", txColOut, {64'h07070707_07070707, 8'hff});
        axW(`ERF_A_SEQCFG, 32'h0);
        @(posedge ref_clk);
        check("tx traffic", txColOut, txColIn);
        repeat (140) @(posedge ref_clk);
        check("far clear", {rfRx, rfSt}, 2'b00);
        conclude();
    end
endmodule // test_erf_rx_filter
